// ==== design/loss_monitor_pkg.sv ====
// Constants, register map and types of the interface loss monitor
package loss_monitor_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_MS = 10;
   localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SHARE_LOSS_MS = 2000;
   localparam int TIMER_W = 16;
   localparam logic [15:0] SHARE_LOSS_TICKS = 16'(SHARE_LOSS_MS / TICK_PERIOD_MS);
   // CAN timeouts in hundredths of a second, one tick each
   localparam logic [15:0] CAN_TIMEOUT_MIN = 16'h0001;
   localparam logic [15:0] CAN_TIMEOUT_MAX = 16'hfde8;
   localparam logic [15:0] CAN_TIMEOUT_DEF = 16'h0014;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CAN_ONE_CFG_OFS = 8'h04;
   localparam logic [7:0] CAN_TWO_CFG_OFS = 8'h08;
   localparam logic [7:0] ACK_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;

   // Control register fields
   localparam int CTRL_EN_B_BIT = 0;
   localparam int CTRL_EN_C_BIT = 1;
   localparam int CTRL_EN_RED_BIT = 2;
   localparam int CTRL_EN_CAN_ONE_BIT = 3;
   localparam int CTRL_EN_CAN_TWO_BIT = 4;
   localparam int CTRL_SACK_ONE_BIT = 5;
   localparam int CTRL_SACK_TWO_BIT = 6;
   localparam int CTRL_SEL_LSB = 8;
   localparam int CTRL_SEL_W = 2;

   // CAN config fields
   localparam int CFG_TIMEOUT_LSB = 0;
   localparam int CFG_CLASS_LSB = 16;
   localparam int CFG_CLASS_W = 3;
   localparam int CFG_NODE_LSB = 24;
   localparam int NODE_W = 7;
   localparam logic [6:0] NODE_DEF = 7'h01;

   // Acknowledge register fields (write only)
   localparam int ACK_ONE_BIT = 0;
   localparam int ACK_TWO_BIT = 1;

   // Status register fields
   localparam int ST_B_BIT = 0;
   localparam int ST_C_BIT = 1;
   localparam int ST_RED_BIT = 2;
   localparam int ST_CAN_ONE_BIT = 3;
   localparam int ST_CAN_TWO_BIT = 4;
   localparam int ST_MISSING_BIT = 5;
   localparam int ST_CFG_ERR_BIT = 6;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_PORT_B = 2'h0,
      SEL_PORT_C = 2'h1,
      SEL_PORT_BC = 2'h2
   } share_sel_t;

   typedef enum logic [2:0] {
      CLASS_A = 3'h0,
      CLASS_B = 3'h1,
      CLASS_C = 3'h2,
      CLASS_D = 3'h3,
      CLASS_E = 3'h4,
      CLASS_F = 3'h5,
      CLASS_CONTROL = 3'h6
   } alarm_class_t;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0067;
   localparam logic [31:0] CAN_CFG_RESET = 32'h0001_0014;

endpackage : loss_monitor_pkg

// ==== design/loss_timer.sv ====
// Tick counter that flags expiry when no restart arrives within a limit
`timescale 1ns/1ps
module loss_timer #(
   parameter int W = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic tick,
   input wire logic restart,
   input wire logic [W-1:0] limit,
   output logic expired
);

   logic [W-1:0] count_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !run || restart) begin
         count_r <= '0;
      end else if (tick && (count_r <= limit)) begin
         count_r <= count_r + 1'b1;
      end
   end

   // One tick past the limit, so the free tick phase never cuts the delay short
   // Limit must stay below all ones; a restart clears the expiry at once
   assign expired = run && (count_r > limit);

endmodule : loss_timer

// ==== design/interface_loss_monitor.sv ====
// Interface loss monitor: Ethernet load-share and CAN traffic supervision
//
// Summary of operation
// - Port B selected, no share message 2 s: self-clearing class B alarm.
// - Port C selected, no share message 2 s: self-clearing class B alarm.
// - B/C selected, traffic on one port only for 2 s: redundancy alarm.
// - Each Ethernet supervision has its own enable, on by default.
// - First CAN alarm when no receive PDO arrives before its timeout.
// - First CAN supervision runs only when enabled; default off.
// - First CAN timeout 0.01 to 650.00 s, default 0.20 s, restarts per PDO.
// - Second CAN alarm when enabled (default off) and its timeout expires.
// - Each CAN supervision carries an alarm class A-F or Control, default B.
// - CAN self-acknowledge default yes; otherwise alarm latches until acked.
// - Status shows missing first CAN PDO and its configuration errors.
`timescale 1ns/1ps
module interface_loss_monitor #(
   parameter int TICK_CYCLES = loss_monitor_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic eth_b_share_msg,
   input wire logic eth_c_share_msg,
   input wire logic can_one_rpdo,
   input wire logic can_one_cfg_error,
   input wire logic can_two_rx,
   input wire logic [6:0] can_two_rx_node,
   output logic port_b_share_loss_alarm,
   output logic port_c_share_loss_alarm,
   output logic share_redundancy_alarm,
   output logic can_one_loss_alarm,
   output logic can_two_loss_alarm,
   output logic [2:0] can_one_alarm_class,
   output logic [2:0] can_two_alarm_class,
   output logic can_one_rpdo_missing,
   output logic can_one_cfg_fault
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   generate
      if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ff_ffff) begin : g_bad_tick
         $error("TICK_CYCLES out of range");
      end
   endgenerate

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Clamp a timeout write into the legal range
   function automatic logic [15:0] clamp_timeout(input logic [15:0] v);
      if (v < loss_monitor_pkg::CAN_TIMEOUT_MIN) begin
         return loss_monitor_pkg::CAN_TIMEOUT_MIN;
      end else if (v > loss_monitor_pkg::CAN_TIMEOUT_MAX) begin
         return loss_monitor_pkg::CAN_TIMEOUT_MAX;
      end
      return v;
   endfunction : clamp_timeout

   // Unknown class codes fall back to the default class
   function automatic logic [2:0] legal_class(input logic [2:0] v);
      if (v > loss_monitor_pkg::CLASS_CONTROL) begin
         return loss_monitor_pkg::CLASS_B;
      end
      return v;
   endfunction : legal_class

   // Alarm state with self-acknowledge or latch; a new fault beats an ack
   function automatic logic alarm_next(input logic cur, input logic fault,
                                       input logic self_ack, input logic ack);
      if (fault) begin
         return 1'b1;
      end else if (self_ack) begin
         return 1'b0;
      end
      return cur && !ack;
   endfunction : alarm_next

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic en_b_r;
   logic en_c_r;
   logic en_red_r;
   logic en_can_one_r;
   logic en_can_two_r;
   logic sack_one_r;
   logic sack_two_r;
   logic [1:0] share_sel_r;
   logic [15:0] can_one_timeout_r;
   logic [15:0] can_two_timeout_r;
   logic [2:0] can_one_class_r;
   logic [2:0] can_two_class_r;
   logic [6:0] can_two_node_r;
   logic ack_one;
   logic ack_two;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         en_b_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_EN_B_BIT];
         en_c_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_EN_C_BIT];
         en_red_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_EN_RED_BIT];
         en_can_one_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_EN_CAN_ONE_BIT];
         en_can_two_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_EN_CAN_TWO_BIT];
         sack_one_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_SACK_ONE_BIT];
         sack_two_r <= loss_monitor_pkg::CTRL_RESET[loss_monitor_pkg::CTRL_SACK_TWO_BIT];
         share_sel_r <= loss_monitor_pkg::SEL_PORT_B;
      end else if (wr && addr == loss_monitor_pkg::CTRL_OFS) begin
         en_b_r <= wdata[loss_monitor_pkg::CTRL_EN_B_BIT];
         en_c_r <= wdata[loss_monitor_pkg::CTRL_EN_C_BIT];
         en_red_r <= wdata[loss_monitor_pkg::CTRL_EN_RED_BIT];
         en_can_one_r <= wdata[loss_monitor_pkg::CTRL_EN_CAN_ONE_BIT];
         en_can_two_r <= wdata[loss_monitor_pkg::CTRL_EN_CAN_TWO_BIT];
         sack_one_r <= wdata[loss_monitor_pkg::CTRL_SACK_ONE_BIT];
         sack_two_r <= wdata[loss_monitor_pkg::CTRL_SACK_TWO_BIT];
         share_sel_r <= wdata[loss_monitor_pkg::CTRL_SEL_LSB +: loss_monitor_pkg::CTRL_SEL_W];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         can_one_timeout_r <= loss_monitor_pkg::CAN_TIMEOUT_DEF;
         can_one_class_r <= loss_monitor_pkg::CLASS_B;
      end else if (wr && addr == loss_monitor_pkg::CAN_ONE_CFG_OFS) begin
         can_one_timeout_r <= clamp_timeout(wdata[loss_monitor_pkg::CFG_TIMEOUT_LSB +: 16]);
         can_one_class_r <= legal_class(
            wdata[loss_monitor_pkg::CFG_CLASS_LSB +: loss_monitor_pkg::CFG_CLASS_W]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         can_two_timeout_r <= loss_monitor_pkg::CAN_TIMEOUT_DEF;
         can_two_class_r <= loss_monitor_pkg::CLASS_B;
         can_two_node_r <= loss_monitor_pkg::NODE_DEF;
      end else if (wr && addr == loss_monitor_pkg::CAN_TWO_CFG_OFS) begin
         can_two_timeout_r <= clamp_timeout(wdata[loss_monitor_pkg::CFG_TIMEOUT_LSB +: 16]);
         can_two_class_r <= legal_class(
            wdata[loss_monitor_pkg::CFG_CLASS_LSB +: loss_monitor_pkg::CFG_CLASS_W]);
         can_two_node_r <= wdata[loss_monitor_pkg::CFG_NODE_LSB +: loss_monitor_pkg::NODE_W];
      end
   end

   // Acknowledge is a write pulse, not stored
   assign ack_one = wr && addr == loss_monitor_pkg::ACK_OFS
                    && wdata[loss_monitor_pkg::ACK_ONE_BIT];
   assign ack_two = wr && addr == loss_monitor_pkg::ACK_OFS
                    && wdata[loss_monitor_pkg::ACK_TWO_BIT];

   // ------------------------------------------------------------
   // Common tick
   // ------------------------------------------------------------
   logic [23:0] tick_cnt_r;
   logic tick;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end
   assign tick = tick_cnt_r == 24'(TICK_CYCLES - 1);

   // ------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------
   localparam int N_TIMERS = 4;
   logic [N_TIMERS-1:0] run;
   logic [N_TIMERS-1:0] restart;
   logic [N_TIMERS-1:0] expired;
   logic [15:0] limit [N_TIMERS];
   logic sel_b;
   logic sel_c;
   logic sel_bc;

   assign sel_b = share_sel_r == loss_monitor_pkg::SEL_PORT_B;
   assign sel_c = share_sel_r == loss_monitor_pkg::SEL_PORT_C;
   assign sel_bc = share_sel_r == loss_monitor_pkg::SEL_PORT_BC;

   // Port timers also feed the redundancy check in B/C mode
   assign run[0] = (sel_b && en_b_r) || (sel_bc && en_red_r);
   assign run[1] = (sel_c && en_c_r) || (sel_bc && en_red_r);
   assign run[2] = en_can_one_r;
   assign run[3] = en_can_two_r;
   assign restart[0] = eth_b_share_msg;
   assign restart[1] = eth_c_share_msg;
   assign restart[2] = can_one_rpdo;
   // only the configured node restarts it
   assign restart[3] = can_two_rx && (can_two_rx_node == can_two_node_r);
   assign limit[0] = loss_monitor_pkg::SHARE_LOSS_TICKS;
   assign limit[1] = loss_monitor_pkg::SHARE_LOSS_TICKS;
   assign limit[2] = can_one_timeout_r;
   assign limit[3] = can_two_timeout_r;

   generate
      for (genvar i = 0; i < N_TIMERS; i++) begin : g_timer
         loss_timer #(
            .W(loss_monitor_pkg::TIMER_W)
         ) u_timer (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .run(run[i]),
            .tick(tick),
            .restart(restart[i]),
            .limit(limit[i]),
            .expired(expired[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Alarms
   // ------------------------------------------------------------
   // port B loss, port C loss and redundancy alarms, self-clearing
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         port_b_share_loss_alarm <= 1'b0;
         port_c_share_loss_alarm <= 1'b0;
         share_redundancy_alarm <= 1'b0;
      end else begin
         port_b_share_loss_alarm <= sel_b && en_b_r && expired[0];
         port_c_share_loss_alarm <= sel_c && en_c_r && expired[1];
         share_redundancy_alarm <= sel_bc && en_red_r && (expired[0] != expired[1]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         can_one_loss_alarm <= 1'b0;
         can_two_loss_alarm <= 1'b0;
      end else begin
         can_one_loss_alarm <= en_can_one_r
            && alarm_next(can_one_loss_alarm, expired[2], sack_one_r, ack_one);
         can_two_loss_alarm <= en_can_two_r
            && alarm_next(can_two_loss_alarm, expired[3], sack_two_r, ack_two);
      end
   end

   // missing PDO and config error status
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         can_one_rpdo_missing <= 1'b0;
         can_one_cfg_fault <= 1'b0;
      end else begin
         can_one_rpdo_missing <= expired[2];
         can_one_cfg_fault <= can_one_cfg_error;
      end
   end

   assign can_one_alarm_class = can_one_class_r;
   assign can_two_alarm_class = can_two_class_r;

   // ------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------
   logic [31:0] rdata_nxt;

   always_comb begin
      rdata_nxt = '0;
      case (addr)
         loss_monitor_pkg::CTRL_OFS: begin
            rdata_nxt[loss_monitor_pkg::CTRL_EN_B_BIT] = en_b_r;
            rdata_nxt[loss_monitor_pkg::CTRL_EN_C_BIT] = en_c_r;
            rdata_nxt[loss_monitor_pkg::CTRL_EN_RED_BIT] = en_red_r;
            rdata_nxt[loss_monitor_pkg::CTRL_EN_CAN_ONE_BIT] = en_can_one_r;
            rdata_nxt[loss_monitor_pkg::CTRL_EN_CAN_TWO_BIT] = en_can_two_r;
            rdata_nxt[loss_monitor_pkg::CTRL_SACK_ONE_BIT] = sack_one_r;
            rdata_nxt[loss_monitor_pkg::CTRL_SACK_TWO_BIT] = sack_two_r;
            rdata_nxt[loss_monitor_pkg::CTRL_SEL_LSB +: loss_monitor_pkg::CTRL_SEL_W] =
               share_sel_r;
         end
         loss_monitor_pkg::CAN_ONE_CFG_OFS: begin
            rdata_nxt[loss_monitor_pkg::CFG_TIMEOUT_LSB +: 16] = can_one_timeout_r;
            rdata_nxt[loss_monitor_pkg::CFG_CLASS_LSB +: loss_monitor_pkg::CFG_CLASS_W] =
               can_one_class_r;
         end
         loss_monitor_pkg::CAN_TWO_CFG_OFS: begin
            rdata_nxt[loss_monitor_pkg::CFG_TIMEOUT_LSB +: 16] = can_two_timeout_r;
            rdata_nxt[loss_monitor_pkg::CFG_CLASS_LSB +: loss_monitor_pkg::CFG_CLASS_W] =
               can_two_class_r;
            rdata_nxt[loss_monitor_pkg::CFG_NODE_LSB +: loss_monitor_pkg::NODE_W] =
               can_two_node_r;
         end
         loss_monitor_pkg::STATUS_OFS: begin
            rdata_nxt[loss_monitor_pkg::ST_B_BIT] = port_b_share_loss_alarm;
            rdata_nxt[loss_monitor_pkg::ST_C_BIT] = port_c_share_loss_alarm;
            rdata_nxt[loss_monitor_pkg::ST_RED_BIT] = share_redundancy_alarm;
            rdata_nxt[loss_monitor_pkg::ST_CAN_ONE_BIT] = can_one_loss_alarm;
            rdata_nxt[loss_monitor_pkg::ST_CAN_TWO_BIT] = can_two_loss_alarm;
            rdata_nxt[loss_monitor_pkg::ST_MISSING_BIT] = can_one_rpdo_missing;
            rdata_nxt[loss_monitor_pkg::ST_CFG_ERR_BIT] = can_one_cfg_fault;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !rd) begin
         rdata <= '0;
      end else begin
         rdata <= rdata_nxt;
      end
   end

endmodule : interface_loss_monitor

// ==== bench/loss_monitor_chk.sv ====
// Port-level assertions of the interface loss monitor
`timescale 1ns/1ps
module loss_monitor_chk #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [31:0] rdata,
   input wire logic eth_b_share_msg,
   input wire logic eth_c_share_msg,
   input wire logic can_one_cfg_error,
   input wire logic port_b_share_loss_alarm,
   input wire logic port_c_share_loss_alarm,
   input wire logic share_redundancy_alarm,
   input wire logic can_one_loss_alarm,
   input wire logic can_two_loss_alarm,
   input wire logic [2:0] can_one_alarm_class,
   input wire logic [2:0] can_two_alarm_class,
   input wire logic can_one_rpdo_missing,
   input wire logic can_one_cfg_fault
);
   // One tick of slack: the tick phase is free-running
   localparam int ETH_MIN = 199 * TICK_CYCLES - 1;
   int unsigned quiet_b_r;
   int unsigned quiet_c_r;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || eth_b_share_msg) quiet_b_r <= 0;
      else if (quiet_b_r < ETH_MIN) quiet_b_r <= quiet_b_r + 1;
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst || eth_c_share_msg) quiet_c_r <= 0;
      else if (quiet_c_r < ETH_MIN) quiet_c_r <= quiet_c_r + 1;
   end
   sequence b_restart;
      eth_b_share_msg;
   endsequence
   sequence c_restart;
      eth_c_share_msg;
   endsequence
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_RST_CLEAR: assert property ($fell(sys_rst) |-> rdata == 32'h0 &&
      !port_b_share_loss_alarm && !share_redundancy_alarm && !can_one_loss_alarm)
      else $error("alarm or read data set after reset");
   AST_B_CLEAR: assert property (b_restart |-> ##[1:2] !port_b_share_loss_alarm)
      else $error("port B alarm kept after message");
   AST_C_CLEAR: assert property (c_restart |-> ##[1:2] !port_c_share_loss_alarm)
      else $error("port C alarm kept after message");
   AST_B_LATE: assert property ($rose(port_b_share_loss_alarm) |-> quiet_b_r >= ETH_MIN)
      else $error("port B alarm too early");
   AST_C_LATE: assert property ($rose(port_c_share_loss_alarm) |-> quiet_c_r >= ETH_MIN)
      else $error("port C alarm too early");
   AST_RED_LATE: assert property ($rose(share_redundancy_alarm) |->
      quiet_b_r >= ETH_MIN || quiet_c_r >= ETH_MIN) else $error("redundancy alarm early");
   AST_MISS_ALARM: assert property ($rose(can_one_rpdo_missing) |-> can_one_loss_alarm)
      else $error("missing PDO without alarm");
   AST_CFG_FAULT: assert property (1'b1 |=> can_one_cfg_fault == $past(can_one_cfg_error))
      else $error("config fault not following input");
   AST_CLASS_LEGAL: assert property (can_one_alarm_class != 3'h7 &&
      can_two_alarm_class != 3'h7) else $error("illegal alarm class");
endmodule : loss_monitor_chk

bind interface_loss_monitor loss_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.sys_clk,
   .sys_rst, .rdata, .eth_b_share_msg, .eth_c_share_msg, .can_one_cfg_error,
   .port_b_share_loss_alarm, .port_c_share_loss_alarm, .share_redundancy_alarm,
   .can_one_loss_alarm, .can_two_loss_alarm, .can_one_alarm_class, .can_two_alarm_class,
   .can_one_rpdo_missing, .can_one_cfg_fault);

// ==== bench/traffic_source.sv ====
// Model of peer controllers and CAN nodes sending periodic traffic
`timescale 1ns/1ps
module traffic_source #(
   parameter int PERIOD = 40
) (
   input wire logic sys_clk,
   input wire logic run_b,
   input wire logic run_c,
   input wire logic run_one,
   input wire logic run_two,
   input wire logic [6:0] node,
   output logic eth_b_share_msg,
   output logic eth_c_share_msg,
   output logic can_one_rpdo,
   output logic can_two_rx,
   output logic [6:0] can_two_rx_node
);
   int phase_r = 0;
   always_ff @(posedge sys_clk) begin
      phase_r <= (phase_r == PERIOD - 1) ? 0 : phase_r + 1;
   end
   // Common phase keeps both share ports in step
   assign eth_b_share_msg = run_b && phase_r == 0;
   assign eth_c_share_msg = run_c && phase_r == 0;
   assign can_one_rpdo = run_one && phase_r == 0;
   assign can_two_rx = run_two && phase_r == 0;
   // Id is garbage outside a frame
   assign can_two_rx_node = can_two_rx ? node : ~node;
endmodule : traffic_source

// ==== bench/tb.sv ====
// Self-checking bench of the interface loss monitor
`timescale 1ns/1ps
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, g); miscompares++; end end
module tb;
   localparam int TC = 4;
   localparam int ELIM = 200 * TC;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic cfg_err = 1'b0;
   logic run_b = 1'b0, run_c = 1'b0, run_one = 1'b0, run_two = 1'b0;
   logic [6:0] node = 7'h01;
   logic [31:0] rdata;
   logic msg_b, msg_c, rpdo, rx2, missing, cfg_fault;
   logic [6:0] rx_node;
   logic [2:0] cls1, cls2;
   wire logic [4:0] alm;
   logic [31:0] rv;
   int miscompares = 0;
   int cmp_count = 0;
   always #5 sys_clk = ~sys_clk;
   traffic_source #(.PERIOD(40)) src (.sys_clk(sys_clk), .run_b(run_b), .run_c(run_c),
      .run_one(run_one), .run_two(run_two), .node(node), .eth_b_share_msg(msg_b),
      .eth_c_share_msg(msg_c), .can_one_rpdo(rpdo), .can_two_rx(rx2), .can_two_rx_node(rx_node));
   interface_loss_monitor #(.TICK_CYCLES(TC)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .eth_b_share_msg(msg_b),
      .eth_c_share_msg(msg_c), .can_one_rpdo(rpdo), .can_one_cfg_error(cfg_err),
      .can_two_rx(rx2), .can_two_rx_node(rx_node), .port_b_share_loss_alarm(alm[0]),
      .port_c_share_loss_alarm(alm[1]), .share_redundancy_alarm(alm[2]),
      .can_one_loss_alarm(alm[3]), .can_two_loss_alarm(alm[4]), .can_one_alarm_class(cls1),
      .can_two_alarm_class(cls2), .can_one_rpdo_missing(missing), .can_one_cfg_fault(cfg_fault));
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   // Bounded wait; a timeout counts a mismatch and ends the run
   task automatic waitv(input int i, input logic v, input int n);
      int k;
      k = 0;
      while (alm[i] !== v && k < n) begin
         @(posedge sys_clk);
         #1 k++;
      end
      if (alm[i] !== v) begin
         $display("[FAIL] wait on alarm %0d exp %h got %h", i, v, alm[i]);
         miscompares++;
         conclude();
      end
   endtask : waitv
   task automatic stay0(input int i, input int n);
      int k;
      k = 0;
      while (alm[i] !== 1'b1 && k < n) begin
         @(posedge sys_clk);
         #1 k++;
      end
      `CHK("alarm quiet", 1'b0, alm[i])
   endtask : stay0
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_defaults();
      rreg(loss_monitor_pkg::CTRL_OFS, rv);
      `CHK("ctrl", loss_monitor_pkg::CTRL_RESET, rv)
      rreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, rv);
      `CHK("can1 cfg", loss_monitor_pkg::CAN_CFG_RESET, rv)
      rreg(loss_monitor_pkg::CAN_TWO_CFG_OFS, rv);
      `CHK("can2 cfg", 32'h0101_0014, rv)
      wreg(8'h14, 32'hffff_ffff);
      rreg(8'h14, rv);
      `CHK("unmapped", 32'h0, rv)
      rreg(loss_monitor_pkg::STATUS_OFS, rv);
      `CHK("status", 32'h0, rv)
      `CHK("class1", loss_monitor_pkg::CLASS_B, cls1)
      `CHK("class2", loss_monitor_pkg::CLASS_B, cls2)
   endtask : s_defaults
   task automatic s_single();
      for (int s = 0; s < 2; s++) begin
         wreg(loss_monitor_pkg::CTRL_OFS, loss_monitor_pkg::CTRL_RESET | (32'(s) << 8));
         run_b <= 1'b1;
         run_c <= 1'b1;
         repeat (ELIM + 100) @(posedge sys_clk);
         #1 `CHK("eth alarms", 2'b00, alm[1:0])
         run_b <= 1'b0;
         run_c <= 1'b0;
         stay0(s, ELIM - TC - 45);
         waitv(s, 1'b1, 2 * TC + 60);
         `CHK("selected alarm", 1'b1, alm[s])
         `CHK("other alarm", 1'b0, alm[1 - s])
         run_b <= 1'b1;
         run_c <= 1'b1;
         waitv(s, 1'b0, 50);
         `CHK("self clear", 1'b0, alm[s])
      end
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_0066);
      run_b <= 1'b0;
      stay0(0, ELIM + 60);
   endtask : s_single
   task automatic s_red();
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_0267);
      run_b <= 1'b1;
      run_c <= 1'b0;
      waitv(2, 1'b1, ELIM + 60);
      `CHK("red alarm", 1'b1, alm[2])
      `CHK("port alarms", 2'b00, alm[1:0])
      run_c <= 1'b1;
      waitv(2, 1'b0, 60);
      `CHK("red clear", 1'b0, alm[2])
      run_b <= 1'b0;
      run_c <= 1'b0;
      stay0(2, ELIM + 60);
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_0263);
      run_b <= 1'b1;
      stay0(2, ELIM + 60);
   endtask : s_red
   task automatic s_can1();
      stay0(3, 300);
      wreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, 32'h0007_0000);
      rreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, rv);
      `CHK("clamp low", 32'h0001_0001, rv)
      wreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, 32'h0006_ffff);
      rreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, rv);
      `CHK("clamp high", {16'h0006, loss_monitor_pkg::CAN_TIMEOUT_MAX}, rv)
      `CHK("class ctl", loss_monitor_pkg::CLASS_CONTROL, cls1)
      wreg(loss_monitor_pkg::CAN_ONE_CFG_OFS, 32'h0000_0014);
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_006f);
      `CHK("class a", loss_monitor_pkg::CLASS_A, cls1)
      run_one <= 1'b1;
      stay0(3, 200);
      run_one <= 1'b0;
      stay0(3, 30);
      waitv(3, 1'b1, 2 * TC + 60);
      `CHK("can1 alarm", 1'b1, alm[3])
      `CHK("missing", 1'b1, missing)
      run_one <= 1'b1;
      waitv(3, 1'b0, 50);
      `CHK("self ack", 1'b0, alm[3])
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_004f);
      run_one <= 1'b0;
      waitv(3, 1'b1, 130);
      run_one <= 1'b1;
      repeat (100) @(posedge sys_clk);
      #1 `CHK("latched", 1'b1, alm[3])
      `CHK("missing off", 1'b0, missing)
      wreg(loss_monitor_pkg::ACK_OFS, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("acked", 1'b0, alm[3])
      run_one <= 1'b0;
      waitv(3, 1'b1, 130);
      wreg(loss_monitor_pkg::CTRL_OFS, loss_monitor_pkg::CTRL_RESET);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("disabled", 1'b0, alm[3])
      cfg_err <= 1'b1;
      rreg(loss_monitor_pkg::STATUS_OFS, rv);
      `CHK("cfg fault", 1'b1, rv[6])
      cfg_err <= 1'b0;
   endtask : s_can1
   task automatic s_can2();
      wreg(loss_monitor_pkg::CAN_TWO_CFG_OFS, 32'h0501_0014);
      wreg(loss_monitor_pkg::CTRL_OFS, 32'h0000_0077);
      node <= 7'h03;
      run_two <= 1'b1;
      waitv(4, 1'b1, 130);
      `CHK("node filter", 1'b1, alm[4])
      node <= 7'h05;
      waitv(4, 1'b0, 60);
      `CHK("node restart", 1'b0, alm[4])
      run_two <= 1'b0;
      waitv(4, 1'b1, 130);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1 `CHK("reset alarms", 5'h00, alm)
   endtask : s_can2
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      s_defaults();
      s_single();
      s_red();
      s_can1();
      s_can2();
      conclude();
   end
endmodule : tb
